// File: rtl/dspdec_defs.svh
// Prefix codes, step sizes and the reserved data code mask for the transfer decoder.
`ifndef DSPDEC_DEFS_SVH
`define DSPDEC_DEFS_SVH
`define DSPDEC_TRANSFER_PREFIX 4'hf
`define DSPDEC_PAR_PREFIX      6'h3e
`define DSPDEC_WORD_STEP       32'h0000_0002
`define DSPDEC_LONG_STEP       32'h0000_0004
`define DSPDEC_RESERVED_DATA   16'h005f
`endif

// File: rtl/dspdec_pkg.sv
// Types shared by the transfer decoder modules.
package dspdec_pkg;
  typedef enum logic [1:0] {
    DSPDEC_AM_PREDEC,
    DSPDEC_AM_INDIRECT,
    DSPDEC_AM_POSTINC,
    DSPDEC_AM_INDEX
  } dspdec_amode_t;
  typedef enum logic [1:0] {
    DSPDEC_K_NONE,
    DSPDEC_K_DOUBLE,
    DSPDEC_K_SINGLE,
    DSPDEC_K_PARALLEL
  } dspdec_kind_t;
  typedef enum logic {
    DSPDEC_ST_FIRST,
    DSPDEC_ST_SECOND
  } dspdec_state_t;
endpackage : dspdec_pkg

// File: rtl/dspdec_agu.sv
// Address generator for one transfer: access address and updated register.
`timescale 1ns/1ns
`include "dspdec_defs.svh"
module dspdec_agu
  import dspdec_pkg::*;
(
  // Request
  input  wire logic [1:0]  mode,
  input  wire logic        long_size,
  input  wire logic        enable,
  // Register values
  input  wire logic [31:0] addr_val,
  input  wire logic [31:0] index_val,
  // Results
  output logic      [31:0] access_addr,
  output logic      [31:0] new_addr,
  output logic             write_back
);
  logic [31:0] step;
  always_comb begin
    step = long_size ? `DSPDEC_LONG_STEP : `DSPDEC_WORD_STEP;
    access_addr = addr_val;
    new_addr = addr_val;
    write_back = enable;
    case (dspdec_amode_t'(mode))
      DSPDEC_AM_PREDEC: begin
        new_addr = addr_val - step;
        access_addr = addr_val - step;
      end
      DSPDEC_AM_INDIRECT: new_addr = addr_val;
      DSPDEC_AM_POSTINC: new_addr = addr_val + step;
      DSPDEC_AM_INDEX: new_addr = addr_val + index_val;
      default: new_addr = addr_val;
    endcase
  end
endmodule : dspdec_agu

// File: rtl/dspdec_top.sv
// Decoder for signal-processing transfer and parallel instruction words.
`timescale 1ns/1ns
`include "dspdec_defs.svh"
module dspdec_top
  import dspdec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Fetch side
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_word,
  // Address register values
  input  wire logic [31:0] r2_val,
  input  wire logic [31:0] r3_val,
  input  wire logic [31:0] r4_val,
  input  wire logic [31:0] r5_val,
  input  wire logic [31:0] r6_val,
  input  wire logic [31:0] r7_val,
  input  wire logic [31:0] x_index_reg,
  input  wire logic [31:0] y_index_reg,
  // Decode result common
  output logic             dec_valid,
  output logic [1:0]       dec_kind,
  output logic             dec_reserved,
  // X half of a double transfer
  output logic             x_mem_en,
  output logic             x_store,
  output logic             x_addr_sel,
  output logic             x_data_sel,
  output logic [1:0]       x_mode,
  output logic [31:0]      x_access_addr,
  output logic             x_addr_wr,
  output logic [31:0]      x_addr_new,
  // Y half of a double transfer
  output logic             y_mem_en,
  output logic             y_store,
  output logic             y_addr_sel,
  output logic             y_data_sel,
  output logic [1:0]       y_mode,
  output logic [31:0]      y_access_addr,
  output logic             y_addr_wr,
  output logic [31:0]      y_addr_new,
  // Single transfer
  output logic             s_mem_en,
  output logic             s_store,
  output logic             s_long,
  output logic [1:0]       single_addr_sel,
  output logic [3:0]       single_data_sel,
  output logic [1:0]       s_mode,
  output logic [31:0]      s_access_addr,
  output logic             s_addr_wr,
  output logic [31:0]      s_addr_new,
  // Parallel instruction fields
  output logic [15:0]      par_transfer_field,
  output logic [15:0]      par_operation_field,
  output logic             par_alu_go,
  output logic             par_mul_go
);
  // ===========================================================================
  // State
  typedef struct packed {
    dspdec_state_t st;
    logic [15:0]   first_half;
    logic          valid;
    logic [1:0]    kind;
    logic          reserved;
    logic          xm;
    logic          xs;
    logic          xa;
    logic          xd;
    logic [1:0]    xmode;
    logic [31:0]   xacc;
    logic          xwr;
    logic [31:0]   xnew;
    logic          ym;
    logic          ys;
    logic          ya;
    logic          yd;
    logic [1:0]    ymode;
    logic [31:0]   yacc;
    logic          ywr;
    logic [31:0]   ynew;
    logic          sm;
    logic          ss;
    logic          sl;
    logic [1:0]    sa;
    logic [3:0]    sd;
    logic [1:0]    smode;
    logic [31:0]   sacc;
    logic          swr;
    logic [31:0]   snew;
    logic [15:0]   pa;
    logic [15:0]   pb;
    logic          palu;
    logic          pmul;
  } dspdec_state_r_t;

  dspdec_state_r_t s_r;
  dspdec_state_r_t s_nxt;

  // ===========================================================================
  // Combinational field extraction
  logic        is_transfer;
  logic        is_double;
  logic        is_single;
  logic        is_par;
  logic [1:0]  xm_code;
  logic [1:0]  ym_code;
  logic [31:0] x_base;
  logic [31:0] y_base;
  logic [31:0] s_base;
  logic [31:0] x_acc_w;
  logic [31:0] x_new_w;
  logic        x_wr_w;
  logic [31:0] y_acc_w;
  logic [31:0] y_new_w;
  logic        y_wr_w;
  logic [31:0] s_acc_w;
  logic [31:0] s_new_w;
  logic        s_wr_w;
  // A set bit marks a data register code that is reserved.
  localparam logic [15:0] reserved_mask = `DSPDEC_RESERVED_DATA;

  always_comb begin
    is_transfer = (fetch_word[15:12] == `DSPDEC_TRANSFER_PREFIX);
    is_par = (fetch_word[15:10] == `DSPDEC_PAR_PREFIX);
    is_double = is_transfer && (fetch_word[11:10] == 2'b00);
    is_single = is_transfer && (fetch_word[11:10] == 2'b01);
    xm_code = fetch_word[3:2];
    ym_code = fetch_word[1:0];
    x_base = fetch_word[9] ? r5_val : r4_val;
    y_base = fetch_word[8] ? r7_val : r6_val;
    case (fetch_word[9:8])
      2'b00: s_base = r4_val;
      2'b01: s_base = r5_val;
      2'b10: s_base = r2_val;
      default: s_base = r3_val;
    endcase
  end

  // Double halves never use pre-decrement: their mode 00 means no transfer.
  dspdec_agu u_agu_x (
    .mode        (xm_code),
    .long_size   (1'b0),
    .enable      (is_double && (xm_code != 2'b00)),
    .addr_val    (x_base),
    .index_val   (x_index_reg),
    .access_addr (x_acc_w),
    .new_addr    (x_new_w),
    .write_back  (x_wr_w)
  );

  dspdec_agu u_agu_y (
    .mode        (ym_code),
    .long_size   (1'b0),
    .enable      (is_double && (ym_code != 2'b00)),
    .addr_val    (y_base),
    .index_val   (y_index_reg),
    .access_addr (y_acc_w),
    .new_addr    (y_new_w),
    .write_back  (y_wr_w)
  );

  dspdec_agu u_agu_s (
    .mode        (fetch_word[3:2]),
    .long_size   (fetch_word[1]),
    .enable      (is_single),
    .addr_val    (s_base),
    .index_val   (x_index_reg),
    .access_addr (s_acc_w),
    .new_addr    (s_new_w),
    .write_back  (s_wr_w)
  );

  // ===========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.xm = 1'b0;
    s_nxt.xwr = 1'b0;
    s_nxt.ym = 1'b0;
    s_nxt.ywr = 1'b0;
    s_nxt.sm = 1'b0;
    s_nxt.swr = 1'b0;
    s_nxt.palu = 1'b0;
    s_nxt.pmul = 1'b0;
    if (fetch_valid) begin
      case (s_r.st)
        DSPDEC_ST_FIRST: begin
          if (is_par) begin
            s_nxt.first_half = fetch_word;
            s_nxt.st = DSPDEC_ST_SECOND;
          end else begin
            s_nxt.valid = 1'b1;
            s_nxt.reserved = 1'b0;
            s_nxt.kind = DSPDEC_K_NONE;
            if (is_double) begin
              s_nxt.kind = DSPDEC_K_DOUBLE;
              s_nxt.xm = (xm_code != 2'b00);
              s_nxt.xs = fetch_word[5];
              s_nxt.xa = fetch_word[9];
              s_nxt.xd = fetch_word[7];
              s_nxt.xmode = xm_code;
              s_nxt.xacc = x_acc_w;
              s_nxt.xwr = x_wr_w;
              s_nxt.xnew = x_new_w;
              s_nxt.ym = (ym_code != 2'b00);
              s_nxt.ys = fetch_word[4];
              s_nxt.ya = fetch_word[8];
              s_nxt.yd = fetch_word[6];
              s_nxt.ymode = ym_code;
              s_nxt.yacc = y_acc_w;
              s_nxt.ywr = y_wr_w;
              s_nxt.ynew = y_new_w;
            end else if (is_single) begin
              s_nxt.kind = DSPDEC_K_SINGLE;
              s_nxt.sd = fetch_word[7:4];
              // Reserved data codes raise a flag and block the access.
              s_nxt.reserved = reserved_mask[fetch_word[7:4]];
              s_nxt.sm = !s_nxt.reserved;
              s_nxt.ss = fetch_word[0];
              s_nxt.sl = fetch_word[1];
              s_nxt.sa = fetch_word[9:8];
              s_nxt.smode = fetch_word[3:2];
              s_nxt.sacc = s_acc_w;
              s_nxt.swr = s_wr_w && !s_nxt.reserved;
              s_nxt.snew = s_new_w;
            end
          end
        end
        DSPDEC_ST_SECOND: begin
          s_nxt.st = DSPDEC_ST_FIRST;
          s_nxt.valid = 1'b1;
          s_nxt.reserved = 1'b0;
          s_nxt.kind = DSPDEC_K_PARALLEL;
          s_nxt.pa = s_r.first_half;
          s_nxt.pb = fetch_word;
          s_nxt.palu = 1'b1;
          s_nxt.pmul = 1'b1;
        end
        default: s_nxt.st = DSPDEC_ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ===========================================================================
  // Outputs, all straight from the state register
  assign dec_valid           = s_r.valid;
  assign dec_kind            = s_r.kind;
  assign dec_reserved        = s_r.reserved;
  assign x_mem_en            = s_r.xm;
  assign x_store             = s_r.xs;
  assign x_addr_sel          = s_r.xa;
  assign x_data_sel          = s_r.xd;
  assign x_mode              = s_r.xmode;
  assign x_access_addr       = s_r.xacc;
  assign x_addr_wr           = s_r.xwr;
  assign x_addr_new          = s_r.xnew;
  assign y_mem_en            = s_r.ym;
  assign y_store             = s_r.ys;
  assign y_addr_sel          = s_r.ya;
  assign y_data_sel          = s_r.yd;
  assign y_mode              = s_r.ymode;
  assign y_access_addr       = s_r.yacc;
  assign y_addr_wr           = s_r.ywr;
  assign y_addr_new          = s_r.ynew;
  assign s_mem_en            = s_r.sm;
  assign s_store             = s_r.ss;
  assign s_long              = s_r.sl;
  assign single_addr_sel     = s_r.sa;
  assign single_data_sel     = s_r.sd;
  assign s_mode              = s_r.smode;
  assign s_access_addr       = s_r.sacc;
  assign s_addr_wr           = s_r.swr;
  assign s_addr_new          = s_r.snew;
  assign par_transfer_field  = s_r.pa;
  assign par_operation_field = s_r.pb;
  assign par_alu_go          = s_r.palu;
  assign par_mul_go          = s_r.pmul;
endmodule : dspdec_top

// File: verification/dspdec_properties.sv
// Port-level checks for the transfer decoder.
`timescale 1ns/1ns
module dspdec_properties (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Fetch side
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_word,
  // Results
  input wire logic        dec_valid,
  input wire logic [1:0]  dec_kind,
  input wire logic        dec_reserved,
  input wire logic        x_mem_en,
  input wire logic        x_store,
  input wire logic        x_addr_sel,
  input wire logic [1:0]  x_mode,
  input wire logic        x_addr_wr,
  input wire logic        s_mem_en,
  input wire logic        s_long,
  input wire logic        s_store,
  input wire logic [1:0]  single_addr_sel,
  input wire logic [1:0]  s_mode,
  input wire logic [31:0] s_access_addr,
  input wire logic        s_addr_wr,
  input wire logic [31:0] s_addr_new,
  input wire logic [15:0] par_operation_field,
  input wire logic        par_alu_go
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ======
  // Helpers
  logic sec_r;
  logic dbl;
  logic sgl;
  logic rsv;
  assign dbl = fetch_valid && !sec_r && fetch_word[15:10] == 6'h3c;
  assign sgl = fetch_valid && !sec_r && fetch_word[15:10] == 6'h3d;
  assign rsv = fetch_word[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
  // A taken first half makes the next taken word its partner, whatever it holds.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) sec_r <= 1'b0;
    else if (fetch_valid) sec_r <= !sec_r && fetch_word[15:10] == 6'h3e;
  end
  // ======
  // Assertions
  a_idle_quiet: assert property (!fetch_valid |=> !dec_valid)
    else $error("result without a fetched word");
  a_double_kind: assert property (dbl |=> dec_valid && dec_kind == 2'h1)
    else $error("double word not reported");
  a_x_fields: assert property (dbl |=> x_addr_sel == $past(fetch_word[9])
    && x_store == $past(fetch_word[5]) && x_mode == $past(fetch_word[3:2]))
    else $error("x half fields wrong");
  a_nop_half: assert property (dbl && fetch_word[3:2] == 2'h0 |=> !x_mem_en && !x_addr_wr)
    else $error("idle x half made an access");
  a_single_fields: assert property (sgl && !rsv |=> dec_kind == 2'h2
    && single_addr_sel == $past(fetch_word[9:8])
    && {s_mode, s_long, s_store} == $past(fetch_word[3:0]))
    else $error("single fields wrong");
  a_reserved_block: assert property (sgl && rsv |=> dec_reserved && !s_mem_en && !s_addr_wr)
    else $error("reserved code not blocked");
  a_predec_first: assert property (s_mem_en && s_mode == 2'h0 |-> s_access_addr == s_addr_new)
    else $error("pre-decrement access used old address");
  a_par_pair: assert property (fetch_valid && sec_r |=> dec_kind == 2'h3 && par_alu_go
    && par_operation_field == $past(fetch_word))
    else $error("parallel halves not paired");
  c_double: cover property (dbl);
  c_single_rsv: cover property (sgl && rsv);
  c_parallel: cover property (fetch_valid && sec_r);
endmodule : dspdec_properties

bind dspdec_top dspdec_properties u_props (
  .clk_sys             (clk_sys),
  .resetn              (resetn),
  .fetch_valid         (fetch_valid),
  .fetch_word          (fetch_word),
  .dec_valid           (dec_valid),
  .dec_kind            (dec_kind),
  .dec_reserved        (dec_reserved),
  .x_mem_en            (x_mem_en),
  .x_store             (x_store),
  .x_addr_sel          (x_addr_sel),
  .x_mode              (x_mode),
  .x_addr_wr           (x_addr_wr),
  .s_mem_en            (s_mem_en),
  .s_long              (s_long),
  .s_store             (s_store),
  .single_addr_sel     (single_addr_sel),
  .s_mode              (s_mode),
  .s_access_addr       (s_access_addr),
  .s_addr_wr           (s_addr_wr),
  .s_addr_new          (s_addr_new),
  .par_operation_field (par_operation_field),
  .par_alu_go          (par_alu_go)
);

// File: verification/dspdec_fetch_model.sv
// Fetch stage model: hands over instruction halves and register values.
`timescale 1ns/1ns
module dspdec_fetch_model (
  // Clock
  input wire logic    clk_sys,
  // Fetch side
  output logic        fetch_valid,
  output logic [15:0] fetch_word,
  // Register view
  output logic [31:0] r2_val,
  output logic [31:0] r3_val,
  output logic [31:0] r4_val,
  output logic [31:0] r5_val,
  output logic [31:0] r6_val,
  output logic [31:0] r7_val,
  output logic [31:0] x_index_reg,
  output logic [31:0] y_index_reg
);
  initial begin
    fetch_valid = 1'b0;
    fetch_word  = 16'h0000;
    r2_val      = 32'h0000_2000;
    r3_val      = 32'h0000_3000;
    r4_val      = 32'h0000_4000;
    r5_val      = 32'h0000_5000;
    r6_val      = 32'h0000_6000;
    r7_val      = 32'h0000_7000;
    x_index_reg = 32'h0000_0100;
    y_index_reg = 32'h0000_0200;
  end
  // The word stays up until the edge that takes it; callers chain sends back to back.
  task automatic send(input logic [15:0] w);
    fetch_valid = 1'b1;
    fetch_word  = w;
    @(posedge clk_sys);
    #1;
  endtask : send
  // An idle bus must not look like the last word, so it is inverted.
  task automatic idle();
    fetch_valid = 1'b0;
    fetch_word  = ~fetch_word;
    @(posedge clk_sys);
    #1;
  endtask : idle
endmodule : dspdec_fetch_model

// File: verification/dspdec_tb_top.sv
// Self-checking bench for the transfer decoder.
`timescale 1ns/1ns
module dspdec_tb_top;
  import dspdec_pkg::*;
  logic clk_sys, resetn, fetch_valid;
  logic [15:0] fetch_word, par_transfer_field, par_operation_field;
  logic [31:0] r2_val, r3_val, r4_val, r5_val, r6_val, r7_val, x_index_reg, y_index_reg;
  logic dec_valid, dec_reserved, x_mem_en, x_store, x_addr_sel, x_data_sel, x_addr_wr;
  logic y_mem_en, y_store, y_addr_sel, y_data_sel, y_addr_wr, par_alu_go, par_mul_go;
  logic s_mem_en, s_store, s_long, s_addr_wr;
  logic [1:0] dec_kind, x_mode, y_mode, s_mode, single_addr_sel;
  logic [3:0] single_data_sel;
  logic [31:0] x_access_addr, x_addr_new, y_access_addr, y_addr_new, s_access_addr, s_addr_new;
  int n_fail;
  int check_count;
  int cyc;
  dspdec_top u_dut (.*);
  dspdec_fetch_model u_fetch (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ======
  // Reporting
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // ======
  // Scenarios
  task automatic t_double();
    u_fetch.send(16'hf26b);
    chk("kind", 3'h5, {dec_valid, dec_kind});
    chk("x_ctl", 6'h3a, {x_mem_en, x_store, x_addr_sel, x_data_sel, x_mode});
    chk("y_ctl", 6'h27, {y_mem_en, y_store, y_addr_sel, y_data_sel, y_mode});
    chk("x_addr", r5_val, x_access_addr);
    chk("x_new", r5_val + 32'h0000_0002, x_addr_new);
    chk("y_new", r6_val + y_index_reg, y_addr_new);
    chk("y_addr0", r6_val, y_access_addr);
    chk("xy_wr", 2'h3, {x_addr_wr, y_addr_wr});
    u_fetch.send(16'hf101);
    chk("x_idle", 2'h0, {x_mem_en, x_addr_wr});
    chk("y_ctl2", 6'h29, {y_mem_en, y_store, y_addr_sel, y_data_sel, y_mode});
    chk("y_addr", r7_val, y_access_addr);
    $display("double transfers done");
  endtask : t_double
  task automatic t_single();
    logic [31:0] a, st, acc, nw;
    for (int m = 0; m < 4; m++) begin
      for (int sz = 0; sz < 4; sz++) begin
        a   = (m == 0) ? r4_val : (m == 1) ? r5_val : (m == 2) ? r2_val : r3_val;
        st  = sz[1] ? 32'h0000_0004 : 32'h0000_0002;
        acc = (m == 0) ? a - st : a;
        nw  = (m == 0) ? a - st : (m == 2) ? a + st : (m == 3) ? a + x_index_reg : a;
        u_fetch.send({6'h3d, m[1:0], 4'h8, m[1:0], sz[1:0]});
        chk("s_ctl", {1'b1, sz[1:0], m[1:0], m[1:0]},
            {s_mem_en, s_long, s_store, single_addr_sel, s_mode});
        chk("s_addr", acc, s_access_addr);
        chk("s_new", {1'b1, nw}, {s_addr_wr, s_addr_new});
      end
    end
    $display("single transfers done");
  endtask : t_single
  task automatic t_reserved();
    logic rsv;
    for (int c = 0; c < 16; c++) begin
      rsv = c inside {0, 1, 2, 3, 4, 6};
      u_fetch.send({8'hf4, c[3:0], 4'h5});
      chk("s_rsv", {rsv, !rsv, !rsv, c[3:0]},
          {dec_reserved, s_mem_en, s_addr_wr, single_data_sel});
    end
    $display("data codes done");
  endtask : t_reserved
  task automatic t_parallel();
    u_fetch.send(16'hf8a5);
    chk("par_wait", 1'b0, dec_valid);
    u_fetch.send(16'h1234);
    chk("par_go", 5'h1f, {dec_valid, dec_kind, par_alu_go, par_mul_go});
    chk("par_fld", 32'hf8a5_1234, {par_transfer_field, par_operation_field});
    u_fetch.send(16'h1234);
    chk("other", 6'h20, {dec_valid, dec_kind, s_mem_en, x_mem_en, y_mem_en});
    u_fetch.idle();
    chk("quiet", 1'b0, dec_valid);
    $display("parallel done");
  endtask : t_parallel
  // ======
  // Main sequence and hang guard
  initial begin
    resetn = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    chk("rst", 3'h0, {dec_valid, dec_kind});
    resetn = 1'b1;
    t_double();
    t_single();
    t_reserved();
    t_parallel();
    test_done();
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      test_done();
    end
  end
endmodule : dspdec_tb_top
